// >>> design/seq_consts.svh
// constants of the start-up and fault sequencer: strap fields, reset values, timing
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

`define CLK_MHZ 200
`define SS_MIN_NS 1000000
`define SS_STEPS 8'hC8
`define SS_STEP_CYC ((`SS_MIN_NS * `CLK_MHZ) / 1000 / 200)
`define LOW_DLY_NS 1000000
`define LOW_DLY_CYC_DEF ((`LOW_DLY_NS * `CLK_MHZ) / 1000)
`define HICCUP_NS 64'd16000000
`define HICCUP_CYC_DEF ((`HICCUP_NS * 64'd200) / 64'd1000)
`define MIN_ON_NS 50
`define MIN_ON_CYC_DEF ((`MIN_ON_NS * `CLK_MHZ + 999) / 1000)
`define STRAP_SETTLE_CYC 16
`define ADDR_FIXED 3'h1
`define ADDR_CCM_BIT 4
`define RAMP_TUNE_LSB 1
`define VOLT_SEL_LATCH_BIT 0
`define VOLT_SEL_CODE_LSB 1
`define MODE_TOPO_BIT 4
`define MODE_SS_LSB 0
`define RAMP_RST 8'h00
`define CNT_RST 32'h0000_0000

`endif

// >>> design/seq_pkg.sv
// types shared by the sequencer and its strap capture
package seq_pkg;

  // captured strap settings
  typedef struct packed {
    logic [6:0] bus_addr;
    logic       forced_ccm;
    logic [1:0] ramp_tune;
    logic [3:0] ref_code;
    logic       latch_off;
    logic       ramp_emul;
    logic [1:0] ss_sel;
  } strap_cfg_type;

  // analog comparator results
  typedef struct packed {
    logic fb_low;
    logic fb_high;
    logic fb_range;
    logic cur_pos_lim;
    logic cur_neg_lim;
    logic zero_cross;
    logic over_temp;
  } comp_type;

  typedef enum logic [5:0] {
    ST_OFF       = 6'h01,
    ST_SOFT      = 6'h02,
    ST_RUN       = 6'h04,
    ST_DISCH     = 6'h08,
    ST_LATCH_OFF = 6'h10,
    ST_LATCH_LOW = 6'h20
  } state_type;

endpackage

// >>> design/strap_capture.sv
// one-shot capture of the address, voltage-select and mode straps
`timescale 1ns/1ps
`default_nettype none
`include "seq_consts.svh"

module strap_capture #(
  parameter int unsigned SETTLE_CYC = `STRAP_SETTLE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic lockout_in,
  input wire logic [4:0] addr_strap_in,
  input wire logic [4:0] volt_strap_in,
  input wire logic [4:0] mode_strap_in,
  output var seq_pkg::strap_cfg_type cfg_out,
  output logic ready_out
);

  logic [15:0] settle_cnt_ff;
  logic ready_ff;
  logic take;
  seq_pkg::strap_cfg_type cfg_ff;

  // capture only once the supply has been above lockout long enough to settle
  assign take = !ready_ff && !lockout_in && (settle_cnt_ff == 16'(SETTLE_CYC - 1));

  // settle counter restarts whenever lockout returns before capture
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      settle_cnt_ff <= 16'h0000;
    end else if (lockout_in) begin
      settle_cnt_ff <= 16'h0000;
    end else if (!ready_ff && !take) begin
      settle_cnt_ff <= settle_cnt_ff + 16'h0001;
    end
  end

  // ready only falls on a true power cycle, so straps are never re-read
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ready_ff <= 1'b0;
    end else if (take) begin
      ready_ff <= 1'b1;
    end
  end

  // decode of the three straps into held settings
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_ff <= '0;
    end else if (take) begin
      cfg_ff.bus_addr <= {`ADDR_FIXED, addr_strap_in[3:0]};
      cfg_ff.forced_ccm <= addr_strap_in[`ADDR_CCM_BIT];
      cfg_ff.ramp_tune <= addr_strap_in[`RAMP_TUNE_LSB +: 2];
      cfg_ff.ref_code <= volt_strap_in[`VOLT_SEL_CODE_LSB +: 4];
      cfg_ff.latch_off <= volt_strap_in[`VOLT_SEL_LATCH_BIT];
      cfg_ff.ramp_emul <= mode_strap_in[`MODE_TOPO_BIT];
      cfg_ff.ss_sel <= mode_strap_in[`MODE_SS_LSB +: 2];
    end
  end

  assign cfg_out = cfg_ff;
  assign ready_out = ready_ff;

  property p_strap_hold;
    @(posedge clk_in) disable iff (!rst_b_in)
      ready_ff |=> (ready_ff && $stable(cfg_ff));
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("straps changed after capture");

  property p_strap_wait;
    @(posedge clk_in) disable iff (!rst_b_in)
      (lockout_in && !ready_ff) |=> !ready_ff;
  endproperty
  a_strap_wait: assert property (p_strap_wait) else $error("straps taken under lockout");

endmodule // strap_capture

`default_nettype wire

// >>> design/buck_startup_fault_sequencer.sv
// start-up, soft-start and fault-protection sequencer of a step-down converter
`timescale 1ns/1ps
`default_nettype none
`include "seq_consts.svh"

// Operation
// - soft-start lasts 1, 2, 4 or 8 ms as the mode strap picks
// - once enabled, reference ramps from zero to strap level over soft-start
// - supply lockout keeps everything disabled whatever the enable input says
// - lockout does not latch; start-up resumes by itself when supply recovers
// - straps are sampled only after the supply is above lockout
// - high side stays off while valley current is above the limit
// - negative current limit of equal size guards the low side
// - feedback below 68 percent for 1 ms latches both drivers off
// - low-output protection is armed only after soft-start ends
// - feedback above 120 percent: high side off, low side discharges, cycling
// - discharge cycling ends after 1 ms below low threshold: low side latched on
// - latched faults clear only by power cycle or enable toggle, or in hiccup mode after the blanking time
// - out-of-range excursion at 8 percent raises no fault and no latch
// - out-of-range: low side forced on past zero current, negative limit active
// - over-temperature shuts off and restarts by itself, no latch
// - topology strap bit can disable the emulated ramp
// - two address strap bits fine-tune the ramp amplitude
// - strap ratios are read once at power-up, not continuously
// - bus address is fixed upper pattern plus four strap bits
// - address strap picks pulse skipping or forced continuous conduction
// - topology bit one means emulated ramp, zero plain ripple control
// - two low mode bits: 00 1 ms, 01 2 ms, 10 4 ms, 11 8 ms
// - voltage strap picks boot reference and latch-off versus hiccup restart
module buck_startup_fault_sequencer #(
  parameter int unsigned LOW_DLY_CYC = `LOW_DLY_CYC_DEF,
  parameter int unsigned HICCUP_CYC = 32'(`HICCUP_CYC_DEF),
  parameter int unsigned MIN_ON_CYC = `MIN_ON_CYC_DEF,
  parameter int unsigned SETTLE_CYC = `STRAP_SETTLE_CYC,
  parameter int unsigned SS_STEP_LEN = `SS_STEP_CYC
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  input wire logic SUPPLY_LOCKOUT_IN,
  input wire logic ENABLE_THRESHOLD_IN,
  input wire logic ON_REQ_IN,
  input wire seq_pkg::comp_type COMP_IN,
  input wire logic [4:0] ADDR_STRAP_IN,
  input wire logic [4:0] VOLTAGE_SELECT_STRAP_IN,
  input wire logic [4:0] MODE_STRAP_IN,
  output logic HS_ON_OUT,
  output logic LS_ON_OUT,
  output logic [7:0] REF_RAMP_OUT,
  output logic SS_DONE_OUT,
  output logic FAULT_LATCHED_OUT,
  output logic STRAPS_READY_OUT,
  output var seq_pkg::strap_cfg_type STRAP_CFG_OUT
);

  seq_pkg::state_type state_ff;
  seq_pkg::state_type nxt_state;
  seq_pkg::strap_cfg_type cfg;
  logic straps_ready;
  logic run_ok;
  logic clear_req;
  logic [7:0] ramp_ff;
  logic [15:0] step_cnt_ff;
  logic [31:0] low_cnt_ff;
  logic [31:0] hic_cnt_ff;
  logic [31:0] on_cnt_ff;
  logic low_done;
  logic hic_done;
  logic on_min_done;
  logic hs_ff;
  logic ls_ff;
  logic nxt_hs;
  logic nxt_ls;
  logic ss_done_ff;
  logic fault_ff;

  // cycles per ramp step for the chosen soft-start length
  function automatic logic [15:0] step_len(input logic [1:0] sel);
    step_len = 16'(SS_STEP_LEN) << sel;
  endfunction

  // latched fault check, used by the hiccup counter and the fault flag
  function automatic logic is_latched(input seq_pkg::state_type st);
    is_latched = (st == seq_pkg::ST_LATCH_OFF) || (st == seq_pkg::ST_LATCH_LOW);
  endfunction

  strap_capture #(
    .SETTLE_CYC(SETTLE_CYC)
  ) i_strap_capture (
    .clk_in(CLK_SYS_IN),
    .rst_b_in(RST_B_IN),
    .lockout_in(SUPPLY_LOCKOUT_IN),
    .addr_strap_in(ADDR_STRAP_IN),
    .volt_strap_in(VOLTAGE_SELECT_STRAP_IN),
    .mode_strap_in(MODE_STRAP_IN),
    .cfg_out(cfg),
    .ready_out(straps_ready)
  );

  // run permission; lockout overrides enable, temperature is self-clearing
  assign run_ok = straps_ready && !SUPPLY_LOCKOUT_IN && ENABLE_THRESHOLD_IN &&
                  !COMP_IN.over_temp;
  // apart from the hiccup retry, only a supply drop or enable release frees a latched fault
  assign clear_req = SUPPLY_LOCKOUT_IN || !ENABLE_THRESHOLD_IN;
  assign low_done = COMP_IN.fb_low && (low_cnt_ff == 32'(LOW_DLY_CYC - 1));
  assign hic_done = hic_cnt_ff == 32'(HICCUP_CYC - 1);
  assign on_min_done = on_cnt_ff == 32'(MIN_ON_CYC - 1);

  // sequencing state machine
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      seq_pkg::ST_OFF: begin
        if (run_ok) begin
          nxt_state = seq_pkg::ST_SOFT;
        end
      end
      seq_pkg::ST_SOFT: begin
        if (!run_ok) begin
          nxt_state = seq_pkg::ST_OFF;
        end else if (COMP_IN.fb_high) begin
          nxt_state = seq_pkg::ST_DISCH;
        end else if (ramp_ff == `SS_STEPS) begin
          nxt_state = seq_pkg::ST_RUN;
        end
      end
      seq_pkg::ST_RUN: begin
        if (!run_ok) begin
          nxt_state = seq_pkg::ST_OFF;
        end else if (COMP_IN.fb_high) begin
          nxt_state = seq_pkg::ST_DISCH;
        end else if (low_done) begin
          nxt_state = seq_pkg::ST_LATCH_OFF;
        end
      end
      seq_pkg::ST_DISCH: begin
        if (!run_ok) begin
          nxt_state = seq_pkg::ST_OFF;
        end else if (low_done) begin
          nxt_state = seq_pkg::ST_LATCH_LOW;
        end
      end
      seq_pkg::ST_LATCH_OFF, seq_pkg::ST_LATCH_LOW: begin
        if (clear_req) begin
          nxt_state = seq_pkg::ST_OFF;
        end else if (!cfg.latch_off && hic_done && run_ok) begin
          nxt_state = seq_pkg::ST_SOFT;
        end
      end
      default: begin
        nxt_state = seq_pkg::ST_OFF;
      end
    endcase
  end

  // state register
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_ff <= seq_pkg::ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // reference ramp: 200 equal steps from zero, so length scales with step time
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ramp_ff <= `RAMP_RST;
      step_cnt_ff <= 16'h0000;
    end else if (nxt_state == seq_pkg::ST_SOFT && state_ff != seq_pkg::ST_SOFT) begin
      ramp_ff <= `RAMP_RST;
      step_cnt_ff <= 16'h0000;
    end else if (state_ff == seq_pkg::ST_SOFT && nxt_state == seq_pkg::ST_SOFT &&
                 ramp_ff != `SS_STEPS) begin
      if (step_cnt_ff == step_len(cfg.ss_sel) - 16'h0001) begin
        step_cnt_ff <= 16'h0000;
        ramp_ff <= ramp_ff + 8'h01;
      end else begin
        step_cnt_ff <= step_cnt_ff + 16'h0001;
      end
    end else if (nxt_state == seq_pkg::ST_OFF) begin
      ramp_ff <= `RAMP_RST;
      step_cnt_ff <= 16'h0000;
    end
  end

  // low-output delay counter; held at zero during soft-start
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      low_cnt_ff <= `CNT_RST;
    end else if ((state_ff == seq_pkg::ST_RUN || state_ff == seq_pkg::ST_DISCH) &&
                 COMP_IN.fb_low && !low_done) begin
      low_cnt_ff <= low_cnt_ff + 32'h0000_0001;
    end else begin
      low_cnt_ff <= `CNT_RST;
    end
  end

  // hiccup blanking while a fault is latched in hiccup mode
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      hic_cnt_ff <= `CNT_RST;
    end else if (is_latched(state_ff) && !cfg.latch_off && !hic_done) begin
      hic_cnt_ff <= hic_cnt_ff + 32'h0000_0001;
    end else if (!is_latched(state_ff)) begin
      hic_cnt_ff <= `CNT_RST;
    end
  end

  // high-side on-time counter enforcing the minimum pulse
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      on_cnt_ff <= `CNT_RST;
    end else if (hs_ff && !on_min_done) begin
      on_cnt_ff <= on_cnt_ff + 32'h0000_0001;
    end else if (!hs_ff) begin
      on_cnt_ff <= `CNT_RST;
    end
  end

  // gate commands; the two never assert together since ls is off whenever hs is
  always_comb begin
    nxt_hs = 1'b0;
    nxt_ls = 1'b0;
    unique case (nxt_state)
      seq_pkg::ST_SOFT, seq_pkg::ST_RUN: begin
        if (hs_ff) begin
          nxt_hs = !on_min_done || ON_REQ_IN;
        end else begin
          nxt_hs = ON_REQ_IN && !COMP_IN.cur_pos_lim;
        end
        if (!nxt_hs) begin
          // out-of-range skips diode emulation but keeps the negative limit
          nxt_ls = !COMP_IN.cur_neg_lim && (COMP_IN.fb_range || cfg.forced_ccm ||
                   !COMP_IN.zero_cross);
        end
      end
      seq_pkg::ST_DISCH: begin
        if (state_ff != seq_pkg::ST_DISCH) begin
          nxt_ls = !COMP_IN.cur_neg_lim;
        end else if (hs_ff) begin
          nxt_hs = !on_min_done;
          nxt_ls = on_min_done && !COMP_IN.cur_neg_lim;
        end else if (COMP_IN.cur_neg_lim || !ls_ff) begin
          nxt_hs = COMP_IN.cur_neg_lim;
          nxt_ls = !COMP_IN.cur_neg_lim;
        end else begin
          nxt_ls = 1'b1;
        end
      end
      seq_pkg::ST_LATCH_LOW: begin
        nxt_ls = 1'b1;
      end
      seq_pkg::ST_OFF, seq_pkg::ST_LATCH_OFF: begin
        nxt_ls = 1'b0;
      end
    endcase
  end

  // driver registers
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      hs_ff <= 1'b0;
      ls_ff <= 1'b0;
    end else begin
      hs_ff <= nxt_hs;
      ls_ff <= nxt_ls;
    end
  end

  // status flags
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ss_done_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      ss_done_ff <= (nxt_state == seq_pkg::ST_RUN) || (nxt_state == seq_pkg::ST_DISCH &&
                    ss_done_ff);
      fault_ff <= is_latched(nxt_state);
    end
  end

  assign HS_ON_OUT = hs_ff;
  assign LS_ON_OUT = ls_ff;
  assign REF_RAMP_OUT = ramp_ff;
  assign SS_DONE_OUT = ss_done_ff;
  assign FAULT_LATCHED_OUT = fault_ff;
  assign STRAPS_READY_OUT = straps_ready;
  assign STRAP_CFG_OUT = cfg;

  property p_lockout_off;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
      SUPPLY_LOCKOUT_IN |=> (state_ff == seq_pkg::ST_OFF && !hs_ff && !ls_ff);
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("active under lockout");

  property p_auto_restart;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
      (state_ff == seq_pkg::ST_OFF && run_ok) |=> (state_ff == seq_pkg::ST_SOFT);
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("no restart");

  property p_valley;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
      (!hs_ff && COMP_IN.cur_pos_lim && !COMP_IN.cur_neg_lim && state_ff != seq_pkg::ST_DISCH)
      |=> !hs_ff;
  endproperty
  a_valley: assert property (p_valley) else $error("high side on above limit");

  property p_neg_lim;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
      (COMP_IN.cur_neg_lim && nxt_state != seq_pkg::ST_LATCH_LOW) |=> !ls_ff;
  endproperty
  a_neg_lim: assert property (p_neg_lim) else $error("low side past negative limit");

  property p_low_latch;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
      (state_ff == seq_pkg::ST_RUN && run_ok && !COMP_IN.fb_high && low_done)
      |=> (fault_ff && !hs_ff && !ls_ff);
  endproperty
  a_low_latch: assert property (p_low_latch) else $error("low fault not latched");

  property p_low_blank;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
      (state_ff == seq_pkg::ST_SOFT) |-> (low_cnt_ff == `CNT_RST && !fault_ff);
  endproperty
  a_low_blank: assert property (p_low_blank) else $error("low check during soft-start");

  property p_high_enter;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
      (state_ff == seq_pkg::ST_RUN && run_ok && COMP_IN.fb_high) |=>
      (state_ff == seq_pkg::ST_DISCH && !hs_ff);
  endproperty
  a_high_enter: assert property (p_high_enter) else $error("high fault not handled");

  property p_disch_latch;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
      (state_ff == seq_pkg::ST_DISCH && run_ok && low_done) |=> (ls_ff && !hs_ff && fault_ff);
  endproperty
  a_disch_latch: assert property (p_disch_latch) else $error("discharge not latched");

  property p_fault_clear;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
      (fault_ff && !ENABLE_THRESHOLD_IN) |=> !fault_ff ##1 (state_ff == seq_pkg::ST_OFF);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

  property p_temp_off;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
      (COMP_IN.over_temp && !fault_ff) |=> (state_ff == seq_pkg::ST_OFF && !hs_ff && !fault_ff);
  endproperty
  a_temp_off: assert property (p_temp_off) else $error("no thermal shutdown");

endmodule // buck_startup_fault_sequencer

`default_nettype wire

// >>> bench/buck_analog_model.sv
// behavioural comparators, inductor current and die sensor around the sequencer
`timescale 1ns/1ps
`default_nettype none

module buck_analog_model #(
  parameter int LIM = 12
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic hs_in,
  input wire logic ls_in,
  input wire logic load_in,
  input wire logic signed [7:0] load_val_in,
  input wire logic [7:0] fb_pct_in,
  input wire logic hot_in,
  output var seq_pkg::comp_type comp_out,
  output logic signed [7:0] cur_out
);
  // current rises while the high side conducts and falls on the low side
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) cur_out <= 8'sh00;
    else if (load_in) cur_out <= load_val_in;
    else if (hs_in) cur_out <= cur_out + 8'sh01;
    else if (ls_in) cur_out <= cur_out - 8'sh01;
  end

  // feedback thresholds in percent of target; limits equal both ways
  always_comb begin
    comp_out.fb_low = fb_pct_in < 8'h44;
    comp_out.fb_high = fb_pct_in > 8'h78;
    comp_out.fb_range = fb_pct_in > 8'h6C;
    comp_out.cur_pos_lim = cur_out > LIM;
    comp_out.cur_neg_lim = cur_out <= -LIM;
    comp_out.zero_cross = cur_out <= 0;
    comp_out.over_temp = hot_in; // hysteresis lives in the analog sensor
  end
endmodule // buck_analog_model

`default_nettype wire

// >>> bench/buck_startup_fault_sequencer_test.sv
// self-checking bench of the start-up and fault sequencer
`timescale 1ns/1ps
`default_nettype none

module buck_startup_fault_sequencer_test;
  localparam int LOW_DLY = 20;
  localparam int MIN_ON = 10;
  localparam int LIM = 12;
  localparam int SS_STEP = 10; // short ramp step keeps the run small
  localparam int HICCUP = 40;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic lockout = 1'b1;
  logic en = 1'b0;
  logic on_req = 1'b0;
  logic load = 1'b0;
  logic hot = 1'b0;
  logic signed [7:0] load_val = 8'sh00;
  logic [7:0] fb = 8'h64;
  logic [4:0] addr = 5'h00;
  logic [4:0] volt = 5'h00;
  logic [4:0] mode = 5'h00;
  logic hs, ls, ss_done, fault, ready;
  logic [7:0] ramp;
  logic signed [7:0] cur;
  seq_pkg::comp_type comp;
  seq_pkg::strap_cfg_type cfg;
  int bad_count = 0;
  int checks_done = 0;
  int n;

  always #2.5 clk = ~clk;

  buck_startup_fault_sequencer #(.LOW_DLY_CYC(LOW_DLY), .HICCUP_CYC(HICCUP),
    .MIN_ON_CYC(MIN_ON), .SETTLE_CYC(4), .SS_STEP_LEN(SS_STEP)) i_buck_startup_fault_sequencer (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .SUPPLY_LOCKOUT_IN(lockout),
    .ENABLE_THRESHOLD_IN(en), .ON_REQ_IN(on_req), .COMP_IN(comp), .ADDR_STRAP_IN(addr),
    .VOLTAGE_SELECT_STRAP_IN(volt), .MODE_STRAP_IN(mode), .HS_ON_OUT(hs), .LS_ON_OUT(ls),
    .REF_RAMP_OUT(ramp), .SS_DONE_OUT(ss_done), .FAULT_LATCHED_OUT(fault),
    .STRAPS_READY_OUT(ready), .STRAP_CFG_OUT(cfg));

  buck_analog_model #(.LIM(LIM)) i_buck_analog_model (
    .clk_in(clk), .rst_b_in(rst_b), .hs_in(hs), .ls_in(ls), .load_in(load),
    .load_val_in(load_val), .fb_pct_in(fb), .hot_in(hot), .comp_out(comp), .cur_out(cur));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // observed signal by index: 0 hs, 1 ls, 2 fault, 3 ready, 4 done, 5 ramp
  function automatic logic [7:0] sig(input int w);
    case (w)
      0: return {7'h00, hs};
      1: return {7'h00, ls};
      2: return {7'h00, fault};
      3: return {7'h00, ready};
      4: return {7'h00, ss_done};
      default: return ramp;
    endcase
  endfunction

  // bounded wait; n ends as the number of edges taken
  task automatic wait_sig(input int w, input logic [7:0] v, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      #1;
    end while (sig(w) !== v && n < lim);
  endtask

  task automatic do_reset(input logic [4:0] a, input logic [4:0] v, input logic [4:0] m);
    @(posedge clk);
    rst_b <= 1'b0;
    en <= 1'b0;
    lockout <= 1'b1;
    addr <= a;
    volt <= v;
    mode <= m;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  function automatic seq_pkg::strap_cfg_type exp_cfg(input logic [4:0] a, v, m);
    seq_pkg::strap_cfg_type e;
    e.bus_addr = {3'h1, a[3:0]};
    e.forced_ccm = a[4];
    e.ramp_tune = a[2:1];
    e.ref_code = v[4:1];
    e.latch_off = v[0];
    e.ramp_emul = m[4];
    e.ss_sel = m[1:0];
    return e;
  endfunction

  // shoot-through watch: the low side must be off whenever the high side is on
  always @(negedge clk) begin
    if (rst_b && hs === 1'b1) chk(16'(ls), 16'h0000);
  end

  task automatic t_straps();
    do_reset(5'h17, 5'h0B, 5'h13);
    repeat (12) @(posedge clk);
    #1 chk(16'(ready), 16'h0000);
    @(posedge clk) lockout <= 1'b0;
    wait_sig(3, 8'h01, 12);
    chk(16'(ready), 16'h0001);
    chk(cfg, exp_cfg(5'h17, 5'h0B, 5'h13));
    @(posedge clk) addr <= 5'h08;
    volt <= 5'h14;
    mode <= 5'h00;
    repeat (6) @(posedge clk);
    #1 chk(cfg, exp_cfg(5'h17, 5'h0B, 5'h13));
    $display("straps test finished");
  endtask

  // one step of the ramp takes a two-hundredth of the selected duration
  task automatic t_ss_sel();
    for (int s = 0; s < 4; s++) begin
      do_reset(5'h06, 5'h01, {s[0], 2'h0, s[1:0]});
      @(posedge clk) lockout <= 1'b0;
      en <= 1'b1;
      wait_sig(3, 8'h01, 20);
      chk(16'(cfg.ramp_emul), 16'(s[0]));
      wait_sig(5, 8'h01, 20000);
      wait_sig(5, 8'h02, 20000);
      chk(16'(n), 16'(((SS_STEP * 200) << s) / 200));
    end
    $display("soft-start select test finished");
  endtask

  task automatic t_start();
    do_reset(5'h06, 5'h01, 5'h10);
    @(posedge clk) lockout <= 1'b0;
    wait_sig(3, 8'h01, 20);
    @(posedge clk) lockout <= 1'b1;
    en <= 1'b1;
    repeat (40) @(posedge clk);
    #1 chk({ramp, 7'h00, hs}, 16'h0000);
    @(posedge clk) lockout <= 1'b0;
    wait_sig(5, 8'h01, 1100);
    chk(16'(ramp), 16'h0001);
    @(posedge clk) fb <= 8'h32;
    repeat (LOW_DLY * 2) @(posedge clk);
    #1 chk(16'(fault), 16'h0000);
    @(posedge clk) fb <= 8'h64;
    wait_sig(4, 8'h01, 2100);
    chk(16'(ramp), 16'h00C8);
    $display("start-up test finished");
  endtask

  task automatic t_switch();
    @(posedge clk) on_req <= 1'b1;
    @(posedge clk) on_req <= 1'b0;
    wait_sig(0, 8'h00, 40);
    chk(16'(n), 16'(MIN_ON));
    wait_sig(1, 8'h00, 40);
    chk(16'(cur > -LIM), 16'h0001);
    @(posedge clk) load <= 1'b1;
    load_val <= 8'sh14;
    // request only once the high current is in place, so the limit must hold it off
    @(posedge clk) load <= 1'b0;
    on_req <= 1'b1;
    wait_sig(0, 8'h01, 40);
    chk(16'(cur <= LIM), 16'h0001);
    @(posedge clk) on_req <= 1'b0;
    wait_sig(0, 8'h00, 40);
    wait_sig(1, 8'h00, 80);
    $display("switching test finished");
  endtask

  task automatic t_range();
    @(posedge clk) fb <= 8'h6E;
    on_req <= 1'b1;
    @(posedge clk) on_req <= 1'b0;
    wait_sig(0, 8'h00, 40);
    wait_sig(1, 8'h00, 60);
    chk(16'(cur <= -LIM), 16'h0001);
    chk({7'h00, fault, 7'h00, ss_done}, 16'h0001);
    @(posedge clk) fb <= 8'h64;
    $display("out-of-range test finished");
  endtask

  task automatic t_low();
    @(posedge clk) load <= 1'b1;
    load_val <= 8'sh00;
    fb <= 8'h32;
    repeat (LOW_DLY - 5) @(posedge clk);
    load <= 1'b0;
    fb <= 8'h64;
    repeat (5) @(posedge clk);
    #1 chk(16'(fault), 16'h0000);
    @(posedge clk) fb <= 8'h32;
    wait_sig(2, 8'h01, 60);
    chk(16'(n), 16'(LOW_DLY));
    chk({7'h00, hs, 7'h00, ls}, 16'h0000);
    @(posedge clk) en <= 1'b0;
    fb <= 8'h64;
    wait_sig(2, 8'h00, 4);
    chk(16'(fault), 16'h0000);
    @(posedge clk) en <= 1'b1;
    wait_sig(5, 8'h01, 1100);
    chk(16'(ramp), 16'h0001);
    $display("low fault test finished");
  endtask

  task automatic t_high();
    @(posedge clk) fb <= 8'h82;
    wait_sig(1, 8'h01, 4);
    chk(16'(hs), 16'h0000);
    wait_sig(0, 8'h01, 60);
    chk(16'(cur <= -LIM + 1), 16'h0001);
    wait_sig(0, 8'h00, 40);
    chk(16'(n), 16'(MIN_ON));
    wait_sig(1, 8'h01, 3);
    chk(16'(ls), 16'h0001);
    @(posedge clk) fb <= 8'h32;
    wait_sig(2, 8'h01, 80);
    chk(16'(n), 16'(LOW_DLY));
    repeat (10) @(posedge clk);
    #1 chk({7'h00, hs, 7'h00, ls}, 16'h0001);
    @(posedge clk) en <= 1'b0;
    fb <= 8'h64;
    wait_sig(2, 8'h00, 4);
    chk(16'(fault), 16'h0000);
    @(posedge clk) en <= 1'b1;
    $display("high fault test finished");
  endtask

  task automatic t_hot();
    wait_sig(5, 8'h01, 1100);
    @(posedge clk) hot <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({ramp, 6'h00, hs, ls}, 16'h0000);
    @(posedge clk) hot <= 1'b0;
    wait_sig(5, 8'h01, 1100);
    chk({7'h00, fault, ramp}, 16'h0001);
    $display("over-temperature test finished");
  endtask

  // hiccup mode: a latched low fault retries by itself after the blanking time
  task automatic t_hiccup();
    do_reset(5'h06, 5'h00, 5'h10);
    @(posedge clk) lockout <= 1'b0;
    en <= 1'b1;
    wait_sig(4, 8'h01, 2100);
    chk(16'(cfg.latch_off), 16'h0000);
    @(posedge clk) fb <= 8'h32;
    wait_sig(2, 8'h01, 60);
    chk(16'(n), 16'(LOW_DLY));
    wait_sig(2, 8'h00, 60);
    chk(16'(n), 16'(HICCUP));
    chk(16'(ramp), 16'h0000);
    @(posedge clk) fb <= 8'h64;
    $display("hiccup test finished");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence; reset is held for the first two cycles
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_straps();
    t_ss_sel();
    t_start();
    t_switch();
    t_range();
    t_low();
    t_high();
    t_hot();
    t_hiccup();
    wrap_up();
  end

  // watchdog: the sequence needs roughly 5k cycles, so 20k is ample
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule // buck_startup_fault_sequencer_test

`default_nettype wire
